// *** src/swkcfg_pkg.sv ***
// Purpose: constants for the selective-wake configuration register bank
// Assumes: 7-bit register addresses, 8-bit data
// Notes:   offsets are the byte addresses of the serial control port
package swkcfg_pkg;
    localparam int         ADDR_W             = 7;
    localparam int         DATA_W             = 8;
    localparam logic [6:0] OFS_PAYLOAD_BYTE3  = 7'h30;
    localparam logic [6:0] OFS_PAYLOAD_BYTE2  = 7'h31;
    localparam logic [6:0] OFS_PAYLOAD_BYTE1  = 7'h32;
    localparam logic [6:0] OFS_PAYLOAD_BYTE0  = 7'h33;
    localparam logic [6:0] OFS_TOLERANT_CTRL  = 7'h34;
    localparam logic [6:0] OFS_FINE_TRIM      = 7'h38;
    localparam logic [6:0] OFS_OPTIONS        = 7'h39;
    localparam logic [6:0] OFS_CAL_HIGH       = 7'h3A;
    localparam logic [6:0] OFS_CAL_LOW        = 7'h3B;
    localparam logic [7:0] RST_ZERO           = 8'h00;
    localparam logic [7:0] RST_FINE_TRIM      = 8'h10;
    localparam logic [4:0] RST_COARSE_TRIM    = 5'h10;
    localparam logic [1:0] TRIM_UNLOCK_CODE   = 2'h3;
    localparam int         BIT_ERR_CNT_DIS    = 5;
    localparam int         BIT_FILT_BYPASS    = 4;
    localparam int         BIT_FILT_HI        = 3;
    localparam int         BIT_FILT_LO        = 1;
    localparam int         BIT_TOL_EN         = 0;
    localparam logic [5:0] TOL_CTRL_MASK      = 6'h3F;
    localparam int         BIT_RX_SEL         = 7;
    localparam int         COARSE_HI          = 4;
    localparam logic [2:0] FILT_CODE_RESERVED = 3'h6;
    localparam int         FILT_STEP_NS       = 50;
    localparam int         FILT_LONG_NS       = 775;
    localparam int         CLK_PERIOD_NS      = 25;
    localparam logic [7:0] FILT_LONG_CYC      = 8'((FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] FILT_STEP_CYC      = 8'((FILT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// *** src/swkcfg_sync.sv ***
// Purpose: two-flop synchroniser for a level from outside the clock domain
// Assumes: ref_clk domain, active-low asynchronous reset
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
module swkcfg_sync (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_ff;

    // two stages, frozen by the clock enable
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff  <= 1'b0;
            sync_out <= 1'b0;
        end else if (clk_en) begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// *** src/swkcfg_filt_dec.sv ***
// Purpose: decodes the dominant filter time code into a cycle count
// Assumes: 40 MHz clock
// Notes:   code 110 gives zero and flags reserved
`timescale 1ns/1ps
module swkcfg_filt_dec
    import swkcfg_pkg::*;
(
    input  wire logic [2:0] filt_code,
    output logic      [7:0] filt_cycles,
    output logic            filt_reserved
);
    // 50 ns steps for codes 000..101, long setting for 111
    assign filt_reserved = (filt_code == FILT_CODE_RESERVED);
    assign filt_cycles   = (filt_code == 3'h7) ? FILT_LONG_CYC :
                           filt_reserved ? 8'h00 :
                           8'((filt_code + 8'h01) * FILT_STEP_CYC);
endmodule

// *** src/swkcfg_regs.sv ***
// Purpose: selective-wake configuration and status register bank
// Assumes: host accesses arrive as one-cycle strobes from the serial port decoder
// Notes:   unlock field, silence timeout and calibration values come from other logic
//
// Summary of operation
// - payload byte registers hold a full read/write data byte, bit 0 LSB
// - payload, tolerant control and calibration registers reset to zero
// - error counter disabled only when disable bit and tolerant enable both set
// - device clears error counter disable bit when silence timeout expires
// - bypass bit routes receive path around analog filter only
// - filter field selects 50 to 300 ns in 50 ns steps, 775 ns at 111
// - bit 0 turns tolerant mode on or off
// - reserved bits always read zero
// - trim fields written only while unlock field equals 11
// - low five fine trim bits are a monotonic 32-step fine trim
// - options bit 7 selects standard or low-power wake receiver, unlock needed
// - options bits 4:0 hold the non-monotonic coarse trim
// - calibration registers are read-only device values, writes ignored
`timescale 1ns/1ps
module swkcfg_regs
    import swkcfg_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic         soft_rst,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [6:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic [1:0]   trim_unlock,
    input  wire logic         silence_expired,
    input  wire logic         cal_load,
    input  wire logic [7:0]   cal_high_in,
    input  wire logic [7:0]   cal_low_in,
    output logic      [7:0]   reg_rdata_ff,
    output logic              reg_rvalid_ff,
    output logic      [7:0]   payload_byte_zero_ff,
    output logic      [7:0]   payload_byte_one_ff,
    output logic      [7:0]   payload_byte_two_ff,
    output logic      [7:0]   payload_byte_three_ff,
    output logic              tolerant_mode_enable_ff,
    output logic              analog_filter_bypass_ff,
    output logic      [7:0]   dominant_filter_cycles_ff,
    output logic              filter_code_reserved_ff,
    output logic              error_counter_active_ff,
    output logic      [7:0]   oscillator_trim_ff,
    output logic      [4:0]   coarse_trim_ff,
    output logic              wake_receiver_select_ff
);
    logic [7:0] pay0_ff, pay1_ff, pay2_ff, pay3_ff;
    logic [5:0] tol_ff;
    logic [7:0] fine_ff;
    logic [4:0] coarse_ff;
    logic       rxsel_ff;
    logic [7:0] calh_ff, call_ff;
    logic       silence_s;
    logic [7:0] filt_cycles;
    logic       filt_reserved;
    logic [7:0] nxt_rdata;

    // silence timeout comes from another domain
    swkcfg_sync u_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .async_in (silence_expired),
        .sync_out (silence_s)
    );

    swkcfg_filt_dec u_filt (
        .filt_code     (tol_ff[BIT_FILT_HI:BIT_FILT_LO]),
        .filt_cycles   (filt_cycles),
        .filt_reserved (filt_reserved)
    );

    // write decode
    function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
        return a == ofs;
    endfunction

    wire unlocked  = (trim_unlock == TRIM_UNLOCK_CODE);
    wire wr_pay0   = reg_wr && hit(reg_addr, OFS_PAYLOAD_BYTE0);
    wire wr_pay1   = reg_wr && hit(reg_addr, OFS_PAYLOAD_BYTE1);
    wire wr_pay2   = reg_wr && hit(reg_addr, OFS_PAYLOAD_BYTE2);
    wire wr_pay3   = reg_wr && hit(reg_addr, OFS_PAYLOAD_BYTE3);
    wire wr_tol    = reg_wr && hit(reg_addr, OFS_TOLERANT_CTRL);
    wire wr_fine   = reg_wr && hit(reg_addr, OFS_FINE_TRIM) && unlocked;
    wire wr_opt    = reg_wr && hit(reg_addr, OFS_OPTIONS) && unlocked;

    // payload bytes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pay0_ff <= RST_ZERO;
            pay1_ff <= RST_ZERO;
            pay2_ff <= RST_ZERO;
            pay3_ff <= RST_ZERO;
        end else if (clk_en) begin
            if (soft_rst) begin
                pay0_ff <= RST_ZERO;
                pay1_ff <= RST_ZERO;
                pay2_ff <= RST_ZERO;
                pay3_ff <= RST_ZERO;
            end else begin
                if (wr_pay0) pay0_ff <= reg_wdata;
                if (wr_pay1) pay1_ff <= reg_wdata;
                if (wr_pay2) pay2_ff <= reg_wdata;
                if (wr_pay3) pay3_ff <= reg_wdata;
            end
        end
    end

    // tolerant control; hardware clear of bit 5 wins over host write
    logic [5:0] nxt_tol;
    always_comb begin
        nxt_tol = tol_ff;
        if (wr_tol) nxt_tol = reg_wdata[5:0] & TOL_CTRL_MASK;
        if (silence_s) nxt_tol[BIT_ERR_CNT_DIS] = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tol_ff <= RST_ZERO[5:0];
        end else if (clk_en) begin
            tol_ff <= soft_rst ? RST_ZERO[5:0] : nxt_tol;
        end
    end

    // trim and receiver select, writes gated by unlock
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fine_ff   <= RST_FINE_TRIM;
            coarse_ff <= RST_COARSE_TRIM;
            rxsel_ff  <= 1'b0;
        end else if (clk_en) begin
            if (wr_fine) fine_ff <= reg_wdata;
            if (wr_opt) begin
                coarse_ff <= reg_wdata[COARSE_HI:0];
                rxsel_ff  <= reg_wdata[BIT_RX_SEL];
            end
        end
    end

    // calibration readback loaded only by the device
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            calh_ff <= RST_ZERO;
            call_ff <= RST_ZERO;
        end else if (clk_en) begin
            if (soft_rst) begin
                calh_ff <= RST_ZERO;
                call_ff <= RST_ZERO;
            end else if (cal_load) begin
                calh_ff <= cal_high_in;
                call_ff <= cal_low_in;
            end
        end
    end

    // read mux, reserved bits zero
    always_comb begin
        nxt_rdata = RST_ZERO;
        unique case (reg_addr)
            OFS_PAYLOAD_BYTE0: nxt_rdata = pay0_ff;
            OFS_PAYLOAD_BYTE1: nxt_rdata = pay1_ff;
            OFS_PAYLOAD_BYTE2: nxt_rdata = pay2_ff;
            OFS_PAYLOAD_BYTE3: nxt_rdata = pay3_ff;
            OFS_TOLERANT_CTRL: nxt_rdata = {2'b00, tol_ff};
            OFS_FINE_TRIM:     nxt_rdata = fine_ff;
            OFS_OPTIONS:       nxt_rdata = {rxsel_ff, 2'b00, coarse_ff};
            OFS_CAL_HIGH:      nxt_rdata = calh_ff;
            OFS_CAL_LOW:       nxt_rdata = call_ff;
            default:           nxt_rdata = RST_ZERO;
        endcase
    end

    // registered read data and derived controls
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff              <= RST_ZERO;
            reg_rvalid_ff             <= 1'b0;
            payload_byte_zero_ff      <= RST_ZERO;
            payload_byte_one_ff       <= RST_ZERO;
            payload_byte_two_ff       <= RST_ZERO;
            payload_byte_three_ff     <= RST_ZERO;
            tolerant_mode_enable_ff   <= 1'b0;
            analog_filter_bypass_ff   <= 1'b0;
            dominant_filter_cycles_ff <= RST_ZERO;
            filter_code_reserved_ff   <= 1'b0;
            error_counter_active_ff   <= 1'b1;
            oscillator_trim_ff        <= RST_FINE_TRIM;
            coarse_trim_ff            <= RST_COARSE_TRIM;
            wake_receiver_select_ff   <= 1'b0;
        end else if (clk_en) begin
            reg_rdata_ff              <= reg_rd ? nxt_rdata : reg_rdata_ff;
            reg_rvalid_ff             <= reg_rd;
            payload_byte_zero_ff      <= pay0_ff;
            payload_byte_one_ff       <= pay1_ff;
            payload_byte_two_ff       <= pay2_ff;
            payload_byte_three_ff     <= pay3_ff;
            tolerant_mode_enable_ff   <= tol_ff[BIT_TOL_EN];
            analog_filter_bypass_ff   <= tol_ff[BIT_FILT_BYPASS];
            dominant_filter_cycles_ff <= filt_cycles;
            filter_code_reserved_ff   <= filt_reserved;
            error_counter_active_ff   <= !(tol_ff[BIT_ERR_CNT_DIS] && tol_ff[BIT_TOL_EN]);
            oscillator_trim_ff        <= fine_ff;
            coarse_trim_ff            <= coarse_ff;
            wake_receiver_select_ff   <= rxsel_ff;
        end
    end

    // checks on write gating and storage
    AST_LOCKED_FINE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && reg_wr && reg_addr == OFS_FINE_TRIM && !unlocked) |=> $stable(fine_ff))
        else $error("locked fine trim write changed value");
    AST_UNLOCKED_FINE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && wr_fine) |=> fine_ff == $past(reg_wdata))
        else $error("unlocked fine trim write lost");
    AST_RXSEL_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && reg_wr && reg_addr == OFS_OPTIONS && !unlocked) |=> $stable(rxsel_ff) && $stable(coarse_ff))
        else $error("locked options write changed value");
    AST_SILENCE_CLR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && silence_s) |=> !tol_ff[BIT_ERR_CNT_DIS])
        else $error("disable bit not cleared on silence");
    AST_ERR_CNT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && tol_ff[BIT_ERR_CNT_DIS] && !tol_ff[BIT_TOL_EN]) |=> error_counter_active_ff)
        else $error("counter disabled without tolerant mode");
    AST_RSVD_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && reg_rd && reg_addr == OFS_TOLERANT_CTRL) |=> reg_rdata_ff[7:6] == 2'b00)
        else $error("reserved bits read nonzero");
    AST_PAY_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && wr_pay0 && !soft_rst) |=> ##1 payload_byte_zero_ff == $past(reg_wdata, 2))
        else $error("payload byte not stored");
    AST_SOFT_RST: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && soft_rst) |=> tol_ff == 6'h00 && calh_ff == RST_ZERO)
        else $error("soft reset did not clear");
    AST_CAL_RO: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && !cal_load && !soft_rst) |=> $stable(calh_ff) && $stable(call_ff))
        else $error("calibration changed without load");
    AST_FILT_LONG: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && tol_ff[BIT_FILT_HI:BIT_FILT_LO] == 3'h7) |=> dominant_filter_cycles_ff == FILT_LONG_CYC)
        else $error("long filter time wrong");

    // checks on derived controls
    AST_ERR_CNT_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && tol_ff[BIT_ERR_CNT_DIS] && tol_ff[BIT_TOL_EN]) |=> !error_counter_active_ff)
        else $error("counter active although disabled in tolerant mode");
    AST_BYPASS_OUT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en |=> analog_filter_bypass_ff == $past(tol_ff[BIT_FILT_BYPASS]))
        else $error("filter bypass output does not follow its bit");
    AST_TOL_EN_OUT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en |=> tolerant_mode_enable_ff == $past(tol_ff[BIT_TOL_EN]))
        else $error("tolerant mode output does not follow its bit");
    AST_FILT_SHORT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && tol_ff[BIT_FILT_HI:BIT_FILT_LO] == 3'h0) |=> dominant_filter_cycles_ff == FILT_STEP_CYC)
        else $error("shortest filter time wrong");
    AST_FILT_MAX: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && tol_ff[BIT_FILT_HI:BIT_FILT_LO] == 3'h5) |=> dominant_filter_cycles_ff == FILT_STEP_CYC * 8'h06)
        else $error("longest stepped filter time wrong");
    AST_FILT_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en |=> filter_code_reserved_ff == ($past(tol_ff[BIT_FILT_HI:BIT_FILT_LO]) == FILT_CODE_RESERVED))
        else $error("reserved filter code flag wrong");
    AST_FINE_OUT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en |=> oscillator_trim_ff == $past(fine_ff))
        else $error("fine trim output does not follow register");
    AST_COARSE_WR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && wr_opt) |=> coarse_ff == $past(reg_wdata[COARSE_HI:0]))
        else $error("unlocked coarse trim write lost");
    AST_COARSE_OUT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en |=> coarse_trim_ff == $past(coarse_ff))
        else $error("coarse trim output does not follow register");
    AST_RXSEL_WR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && wr_opt) |=> rxsel_ff == $past(reg_wdata[BIT_RX_SEL]))
        else $error("unlocked receiver select write lost");
    AST_RXSEL_OUT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en |=> wake_receiver_select_ff == $past(rxsel_ff))
        else $error("receiver select output does not follow register");

    // checks on reset, readback and clock enable
    AST_PAY_SOFT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && soft_rst) |=> pay0_ff == RST_ZERO && pay3_ff == RST_ZERO && call_ff == RST_ZERO)
        else $error("soft reset left payload or calibration set");
    AST_PAY_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && reg_rd && reg_addr == OFS_PAYLOAD_BYTE0) |=> reg_rdata_ff == $past(pay0_ff))
        else $error("payload byte read wrong");
    AST_OPT_RSVD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && reg_rd && reg_addr == OFS_OPTIONS) |=> reg_rdata_ff[6:5] == 2'b00)
        else $error("options reserved bits read nonzero");
    AST_RVALID: assert property (@(posedge ref_clk) disable iff (!rst_b) // read answer one cycle later
        clk_en |=> reg_rvalid_ff == $past(reg_rd))
        else $error("read valid not one cycle after read strobe");
    AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!rst_b) // clock enable freeze
        !clk_en |=> $stable(pay0_ff) && $stable(tol_ff) && $stable(fine_ff) && $stable(reg_rvalid_ff))
        else $error("state changed while clock enable low");

    // coverage of main scenarios
    COV_UNLOCK_WR: cover property (@(posedge ref_clk) disable iff (!rst_b) clk_en && wr_opt);
    COV_SILENCE: cover property (@(posedge ref_clk) disable iff (!rst_b) clk_en && silence_s && wr_tol);
    COV_READ: cover property (@(posedge ref_clk) disable iff (!rst_b) clk_en && reg_rd && reg_addr == OFS_CAL_LOW);
    COV_LOCKED_WR: cover property (@(posedge ref_clk) disable iff (!rst_b) clk_en && reg_wr && !unlocked);
    COV_FREEZE: cover property (@(posedge ref_clk) disable iff (!rst_b) !clk_en && reg_wr);
endmodule

// *** dv/swkcfg_host.sv ***
// Purpose: host model driving the register strobes of the bank
// Assumes: strobes change at the falling edge of ref_clk
// Notes:   released address and data show inverted values
`timescale 1ns/1ps
module swkcfg_host
    import swkcfg_pkg::*;
(
    input  wire logic ref_clk,
    output logic      reg_wr,
    output logic      reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    // one access held across one sampling edge, then one idle cycle
    task automatic acc(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;   // no stale address after release
        reg_wdata = ~d;
        @(negedge ref_clk);
    endtask
    // receiver change picks low-power and writes coarse trim back
    task automatic set_rx(input logic [4:0] coarse);
        acc(1'b1, 1'b0, OFS_OPTIONS, {3'b100, coarse});
    endtask
    // fine trim update keeps the temperature bits
    task automatic set_fine(input logic [7:0] cur, input logic [4:0] f);
        acc(1'b1, 1'b0, OFS_FINE_TRIM, {cur[7:5], f});
    endtask
endmodule

// *** dv/testbench.sv ***
// Purpose: self-checking bench for the selective-wake register bank
// Assumes: host model issues accesses, reads checked from a queue
// Notes:   clk_en is dropped once to check that the bank freezes
`timescale 1ns/1ps
module testbench
    import swkcfg_pkg::*;
;
    logic ref_clk, rst_b, clk_en, soft_rst, silence_expired, cal_load;
    logic [1:0] trim_unlock;
    logic [7:0] cal_high_in, cal_low_in, reg_wdata, reg_rdata_ff, v;
    logic [7:0] p0, p1, p2, p3, filt_cyc, osc;
    logic [6:0] reg_addr;
    logic [4:0] coarse;
    logic reg_wr, reg_rd, reg_rvalid_ff, tol_en, byp, filt_res, err_act, rx_sel;
    logic [7:0] expq[$];
    logic [7:0] pay[4];
    int miscompares, checks;

    swkcfg_regs swkcfg_regs_inst (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
        .soft_rst(soft_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .trim_unlock(trim_unlock), .silence_expired(silence_expired),
        .cal_load(cal_load), .cal_high_in(cal_high_in), .cal_low_in(cal_low_in),
        .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
        .payload_byte_zero_ff(p0), .payload_byte_one_ff(p1), .payload_byte_two_ff(p2),
        .payload_byte_three_ff(p3), .tolerant_mode_enable_ff(tol_en),
        .analog_filter_bypass_ff(byp), .dominant_filter_cycles_ff(filt_cyc),
        .filter_code_reserved_ff(filt_res), .error_counter_active_ff(err_act),
        .oscillator_trim_ff(osc), .coarse_trim_ff(coarse), .wake_receiver_select_ff(rx_sel));
    swkcfg_host swkcfg_host_inst (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    // clock generator
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // compare and count
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        expq.push_back(e);
        swkcfg_host_inst.acc(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        swkcfg_host_inst.acc(1'b1, 1'b0, a, d);
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // read data watcher takes the oldest note
    always @(negedge ref_clk) begin
        if (reg_rvalid_ff === 1'b1) begin
            if (expq.size() == 0) begin
                cmp(reg_rdata_ff, 8'hxx);
            end else begin
                cmp(reg_rdata_ff, expq.pop_front());
            end
        end
    end
    // watchdog
    initial begin
        repeat (5000) @(negedge ref_clk);
        miscompares++;
        report_and_stop();
    end
    // main sequence
    initial begin
        {rst_b, soft_rst, silence_expired, cal_load} = 4'h0;
        clk_en = 1'b1;
        trim_unlock = 2'h0;
        cal_high_in = 8'h00;
        cal_low_in = 8'h00;
        v = 8'($urandom(32'h3155));
        repeat (10) @(negedge ref_clk);
        rst_b = 1'b1;
        for (int i = 0; i < 5; i++) rd(OFS_PAYLOAD_BYTE3 + 7'(i), 8'h00);
        rd(OFS_CAL_HIGH, 8'h00);
        rd(OFS_CAL_LOW, 8'h00);
        rd(7'h35, 8'h00);
        // payload bytes, writes one idle cycle apart
        for (int i = 0; i < 4; i++) pay[i] = 8'($urandom);
        for (int i = 0; i < 4; i++) wr(OFS_PAYLOAD_BYTE3 + 7'(i), pay[i]);
        for (int i = 0; i < 4; i++) rd(OFS_PAYLOAD_BYTE3 + 7'(i), pay[i]);
        cmp(p3, pay[0]);
        cmp(p2, pay[1]);
        cmp(p1, pay[2]);
        cmp(p0, pay[3]);
        // clock enable low: a write must not land
        clk_en = 1'b0;
        wr(OFS_PAYLOAD_BYTE0, ~pay[3]);
        clk_en = 1'b1;
        rd(OFS_PAYLOAD_BYTE0, pay[3]);
        cmp(p0, pay[3]);
        // every filter code with reserved bits written high
        for (int c = 0; c < 8; c++) begin
            wr(OFS_TOLERANT_CTRL, {4'hD, 3'(c), 1'b1});
            rd(OFS_TOLERANT_CTRL, {4'h1, 3'(c), 1'b1});
            cmp(filt_cyc, (c == 6) ? 8'h00 : 8'(((c == 7) ? 775 : 50 * (c + 1) + 24) / 25));
            cmp({7'h00, filt_res}, {7'h00, c == 6});
            cmp({6'h00, byp, tol_en}, 8'h03);
        end
        wr(OFS_TOLERANT_CTRL, 8'h20);
        cmp({7'h00, err_act}, 8'h01);
        wr(OFS_TOLERANT_CTRL, 8'h21);
        cmp({7'h00, err_act}, 8'h00);
        // host rewrite of the disable bit while silence is reported loses
        silence_expired = 1'b1;
        repeat (2) @(negedge ref_clk);
        wr(OFS_TOLERANT_CTRL, 8'h21);
        silence_expired = 1'b0;
        repeat (3) @(negedge ref_clk);
        rd(OFS_TOLERANT_CTRL, 8'h01);
        cmp({7'h00, err_act}, 8'h01);
        wr(OFS_TOLERANT_CTRL, 8'h00);
        cmp({7'h00, tol_en}, 8'h00);
        // locked trim writes are dropped
        trim_unlock = 2'h2;
        wr(OFS_FINE_TRIM, 8'hEF);
        wr(OFS_OPTIONS, 8'h8F);
        rd(OFS_FINE_TRIM, RST_FINE_TRIM);
        rd(OFS_OPTIONS, {3'b000, RST_COARSE_TRIM});
        trim_unlock = TRIM_UNLOCK_CODE;
        swkcfg_host_inst.set_fine(RST_FINE_TRIM, v[4:0]);
        rd(OFS_FINE_TRIM, {RST_FINE_TRIM[7:5], v[4:0]});
        cmp(osc, {RST_FINE_TRIM[7:5], v[4:0]});
        swkcfg_host_inst.set_rx(RST_COARSE_TRIM);
        rd(OFS_OPTIONS, {3'b100, RST_COARSE_TRIM});
        cmp({rx_sel, 2'b00, coarse}, {3'b100, RST_COARSE_TRIM});
        wr(OFS_OPTIONS, 8'h6B);
        rd(OFS_OPTIONS, 8'h0B);
        // calibration values are read-only
        cal_high_in = 8'($urandom);
        cal_low_in = 8'($urandom);
        cal_load = 1'b1;
        @(negedge ref_clk);
        cal_load = 1'b0;
        wr(OFS_CAL_HIGH, ~cal_high_in);
        wr(OFS_CAL_LOW, ~cal_low_in);
        rd(OFS_CAL_HIGH, cal_high_in);
        rd(OFS_CAL_LOW, cal_low_in);
        // soft reset clears all but trims and receiver select
        wr(OFS_TOLERANT_CTRL, 8'h1F);
        soft_rst = 1'b1;
        @(negedge ref_clk);
        soft_rst = 1'b0;
        @(negedge ref_clk);
        rd(OFS_PAYLOAD_BYTE0, 8'h00);
        rd(OFS_TOLERANT_CTRL, 8'h00);
        rd(OFS_CAL_LOW, 8'h00);
        rd(OFS_OPTIONS, 8'h0B);
        repeat (4) @(negedge ref_clk);
        cmp(8'(expq.size()), 8'h00);
        report_and_stop();
    end
endmodule
